// ### rtl/acip_pkg.sv
// acip_pkg: register map, field layout, codes and counts of the adc input/reference/clock select block
package acip_pkg;

   // ==========================================================
   // register byte offsets
   localparam logic [7:0] CHAN_OFS = 8'h00;
   localparam logic [7:0] REF_OFS  = 8'h04;
   localparam logic [7:0] CLK_OFS  = 8'h08;
   localparam logic [7:0] CONV_OFS = 8'h0c;
   localparam logic [7:0] STAT_OFS = 8'h10;

   // ==========================================================
   // field positions
   localparam int unsigned CHAN_W      = 6;
   localparam int unsigned PREF_LSB    = 0;
   localparam int unsigned PREF_W      = 3;
   localparam int unsigned NREF_BIT    = 4;
   localparam int unsigned CSRC_BIT    = 0;
   localparam int unsigned DIV_LSB     = 8;
   localparam int unsigned DIV_W       = 6;
   localparam int unsigned GO_BIT      = 0;
   localparam int unsigned BUSY_BIT    = 0;
   localparam int unsigned DONE_BIT    = 1;
   localparam int unsigned ACTSRC_BIT  = 2;
   localparam int unsigned HALF_LSB    = 8;

   // ==========================================================
   // values after reset
   localparam logic [5:0] RST_CHAN = 6'h00;
   localparam logic [2:0] RST_PREF = 3'h0;
   localparam logic       RST_NREF = 1'h0;
   localparam logic       RST_CSRC = 1'h0;
   localparam logic [5:0] RST_DIV  = 6'h00;

   // ==========================================================
   // channel and reference codes
   localparam logic [5:0] CH_LAST_PIN = 6'h22;
   localparam logic [5:0] CH_GND      = 6'h3c;
   localparam logic [5:0] CH_TEMP     = 6'h3d;
   localparam logic [5:0] CH_DAC      = 6'h3e;
   localparam logic [5:0] CH_FVR      = 6'h3f;
   localparam int unsigned MAX_PINS   = 35;
   localparam int unsigned ROUTE_W    = 39;
   localparam int unsigned RT_GND     = 35;
   localparam int unsigned RT_TEMP    = 36;
   localparam int unsigned RT_DAC     = 37;
   localparam int unsigned RT_FVR     = 38;

   localparam logic [2:0] PREF_VDD   = 3'h0;
   localparam logic [2:0] PREF_PIN   = 3'h1;
   localparam logic [2:0] PREF_FVR1  = 3'h2;
   localparam logic [2:0] PREF_FVR2  = 3'h3;
   localparam logic [2:0] PREF_FVR4  = 3'h4;
   localparam int unsigned PREF_SRCS = 5;

   // ==========================================================
   // conversion timing: 11.5 periods counted in half periods
   localparam logic [4:0] CONV_HALVES = 5'h17;
   localparam logic [4:0] FIRST_BIT_H = 5'h03;
   localparam logic [4:0] LAST_BIT_H  = 5'h15;

   typedef enum logic [2:0]
   {
      ACIP_IDLE = 3'b001,
      ACIP_WAIT = 3'b010,
      ACIP_CONV = 3'b100
   } acip_state_t;

endpackage

// ### rtl/acip_adc_cfg.sv
// acip_adc_cfg: channel, reference and conversion clock selection of a 10-bit sar adc, apb slave
`timescale 1ns/100ps
`default_nettype none

module acip_adc_cfg
   import acip_pkg::*;
#(
   parameter int unsigned NUM_PORT_PINS = 35
)
(
   input  wire logic                ref_clk,
   input  wire logic                rst_n,
   input  wire logic                clk_en,
   input  wire logic [7:0]          paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                rc_half_tick,
   output logic      [ROUTE_W-1:0]  sh_route,
   output logic      [PREF_SRCS-1:0] pos_ref_route,
   output logic                     neg_ref_is_pin,
   output logic                     conv_clk,
   output logic                     conv_half_tick,
   output logic                     bit_strobe,
   output logic                     conv_busy
);

   // ==========================================================
   // elaboration checks
   if (NUM_PORT_PINS < 1 || NUM_PORT_PINS > MAX_PINS)
   begin : g_bad_pins
      $error("NUM_PORT_PINS must lie in 1..35");
   end

   // ==========================================================
   // decode functions
   function automatic logic [ROUTE_W-1:0] route_decode(input logic [5:0] code);
      logic [ROUTE_W-1:0] r;
      r = '0;
      case (code)
         CH_FVR:  r[RT_FVR]  = 1'b1;
         CH_DAC:  r[RT_DAC]  = 1'b1;
         CH_TEMP: r[RT_TEMP] = 1'b1;
         CH_GND:  r[RT_GND]  = 1'b1;
         default:
         begin
            if (code <= CH_LAST_PIN && 32'(code) < NUM_PORT_PINS)
               r[code] = 1'b1;
         end
      endcase
      return r;
   endfunction

   function automatic logic [PREF_SRCS-1:0] pref_decode(input logic [2:0] code);
      logic [PREF_SRCS-1:0] r;
      r = '0;
      if (code < 3'(PREF_SRCS))
         r[code] = 1'b1;
      return r;
   endfunction

   // ==========================================================
   // software-visible registers
   logic [5:0]  chan_ff;
   logic [2:0]  pref_ff;
   logic        nref_ff;
   logic        csrc_ff;
   logic [5:0]  div_ff;
   logic        done_ff;
   logic        wr_acc;
   logic        rd_acc;
   logic        known_ofs;
   acip_state_t state_ff;
   logic [4:0]  half_cnt_ff;

   assign known_ofs = (paddr == CHAN_OFS) || (paddr == REF_OFS) || (paddr == CLK_OFS)
                      || (paddr == CONV_OFS) || (paddr == STAT_OFS);
   // writes land only at the edge that completes the transfer, when pready is seen high
   assign wr_acc = psel && penable && pready && pwrite && known_ofs;
   assign rd_acc = psel && penable && !pready && !pwrite;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         chan_ff <= RST_CHAN;
         pref_ff <= RST_PREF;
         nref_ff <= RST_NREF;
         csrc_ff <= RST_CSRC;
         div_ff  <= RST_DIV;
      end
      else if (clk_en && wr_acc)
      begin
         if (paddr == CHAN_OFS)
            chan_ff <= pwdata[CHAN_W-1:0];
         if (paddr == REF_OFS)
         begin
            pref_ff <= pwdata[PREF_LSB +: PREF_W];
            nref_ff <= pwdata[NREF_BIT];
         end
         if (paddr == CLK_OFS)
         begin
            csrc_ff <= pwdata[CSRC_BIT];
            div_ff  <= pwdata[DIV_LSB +: DIV_W];
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end
      else if (clk_en)
      begin
         pready  <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !known_ofs;
         if (rd_acc)
         begin
            prdata <= '0;
            case (paddr)
               CHAN_OFS: prdata[CHAN_W-1:0] <= chan_ff;
               REF_OFS:
               begin
                  prdata[PREF_LSB +: PREF_W] <= pref_ff;
                  prdata[NREF_BIT]           <= nref_ff;
               end
               CLK_OFS:
               begin
                  prdata[CSRC_BIT]         <= csrc_ff;
                  prdata[DIV_LSB +: DIV_W] <= div_ff;
               end
               CONV_OFS: prdata[GO_BIT] <= (state_ff != ACIP_IDLE);
               STAT_OFS:
               begin
                  prdata[BUSY_BIT]          <= (state_ff != ACIP_IDLE);
                  prdata[DONE_BIT]          <= done_ff;
                  prdata[ACTSRC_BIT]        <= csrc_ff;
                  prdata[HALF_LSB +: 5]     <= half_cnt_ff;
               end
               default: prdata <= '0;
            endcase
         end
      end
   end

   // ==========================================================
   // conversion clock generation
   logic [5:0] div_cnt_ff;
   logic       half_tick;

   // divided source: half period is code+1 cycles, so the full period is 2*(code+1)
   assign half_tick = csrc_ff ? rc_half_tick : (div_cnt_ff == div_ff);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         div_cnt_ff <= '0;
      else if (clk_en)
      begin
         // restart on a divider or source write so the new rate starts cleanly
         if (csrc_ff || half_tick || (wr_acc && paddr == CLK_OFS))
            div_cnt_ff <= '0;
         else
            div_cnt_ff <= div_cnt_ff + 6'h01;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         conv_clk       <= 1'b0;
         conv_half_tick <= 1'b0;
      end
      else if (clk_en)
      begin
         conv_half_tick <= half_tick;
         if (half_tick)
            conv_clk <= !conv_clk;
      end
   end

   // ==========================================================
   // analog selections, applied every cycle, or only on rc ticks when the rc source is selected
   logic apply_cfg;

   // the rc source only updates selections on its own ticks, so writes lag
   assign apply_cfg = csrc_ff ? rc_half_tick : 1'b1;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_route       <= '0;
         pos_ref_route  <= '0;
         neg_ref_is_pin <= 1'b0;
      end
      else if (clk_en && apply_cfg)
      begin
         sh_route       <= route_decode(chan_ff);
         pos_ref_route  <= pref_decode(pref_ff);
         neg_ref_is_pin <= nref_ff;
      end
   end

   // ==========================================================
   // conversion sequencer
   logic go_wr;
   logic stop_wr;
   logic conv_end;

   assign go_wr    = wr_acc && (paddr == CONV_OFS) && pwdata[GO_BIT];
   assign stop_wr  = wr_acc && (paddr == CONV_OFS) && !pwdata[GO_BIT];
   assign conv_end = (state_ff == ACIP_CONV) && half_tick && (half_cnt_ff == CONV_HALVES - 5'h01);

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_ff    <= ACIP_IDLE;
         half_cnt_ff <= '0;
      end
      else if (clk_en)
      begin
         case (state_ff)
            ACIP_IDLE:
            begin
               half_cnt_ff <= '0;
               if (go_wr)
                  state_ff <= ACIP_WAIT;
            end
            ACIP_WAIT:
            begin
               // align the start to a conversion clock edge
               if (stop_wr)
                  state_ff <= ACIP_IDLE;
               else if (half_tick)
                  state_ff <= ACIP_CONV;
            end
            ACIP_CONV:
            begin
               if (stop_wr || conv_end)
                  state_ff <= ACIP_IDLE;
               if (half_tick)
                  half_cnt_ff <= half_cnt_ff + 5'h01;
            end
            default: state_ff <= ACIP_IDLE;
         endcase
      end
   end

   // done is sticky; a completion in the clearing cycle wins
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         done_ff <= 1'b0;
      else if (clk_en)
      begin
         if (conv_end)
            done_ff <= 1'b1;
         else if (wr_acc && paddr == STAT_OFS && pwdata[DONE_BIT])
            done_ff <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         bit_strobe <= 1'b0;
         conv_busy  <= 1'b0;
      end
      else if (clk_en)
      begin
         // one decision per full period after the first sampling period
         bit_strobe <= (state_ff == ACIP_CONV) && half_tick && half_cnt_ff[0]
                       && (half_cnt_ff >= FIRST_BIT_H) && (half_cnt_ff <= LAST_BIT_H);
         conv_busy  <= (state_ff == ACIP_CONV) && !conv_end && !stop_wr;
      end
   end

   // ==========================================================
   // checks
   chk_route_onehot: assert property (@(posedge ref_clk) disable iff (!rst_n)
      $onehot0(sh_route)) else $error("more than one source routed");

   chk_route_fvr: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && apply_cfg && chan_ff == CH_FVR) |=> sh_route[RT_FVR]) else $error("fvr not routed");

   chk_route_resv: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && apply_cfg && chan_ff > CH_LAST_PIN && chan_ff < CH_GND) |=> (sh_route == '0))
      else $error("reserved code routed a source");

   chk_route_pin: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && apply_cfg && chan_ff <= CH_LAST_PIN && 32'(chan_ff) < NUM_PORT_PINS)
      |=> sh_route[$past(chan_ff)]) else $error("pin not routed");

   chk_pref_map: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && apply_cfg && pref_ff == PREF_FVR4) |=> pos_ref_route[4] && $onehot(pos_ref_route))
      else $error("positive reference wrong");

   chk_nref_follow: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && apply_cfg) |=> (neg_ref_is_pin == $past(nref_ff))) else $error("negative reference lag");

   chk_div_period: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && !csrc_ff && div_ff == 6'h00 && half_tick && !(wr_acc && paddr == CLK_OFS))
      ##1 (clk_en && !csrc_ff && $stable(div_ff)) |-> half_tick) else $error("divide by 2 wrong");

   chk_rc_source: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (rst_n && clk_en && csrc_ff) |=> (conv_half_tick == $past(rc_half_tick))) else $error("rc clock not used");

   chk_conv_len: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (clk_en && state_ff == ACIP_CONV && half_tick && half_cnt_ff == 5'h16) |=> (state_ff == ACIP_IDLE) && done_ff)
      else $error("conversion not 11.5 periods");

   chk_bit_odd: assert property (@(posedge ref_clk) disable iff (!rst_n)
      bit_strobe |-> $past(half_cnt_ff[0]) && $past(state_ff == ACIP_CONV)) else $error("bit strobe misplaced");

endmodule

`default_nettype wire

// ### sim/acip_rc_src.sv
// acip_rc_src: stand-in for the internal rc conversion oscillator, giving half-period ticks
`timescale 1ns/100ps
`default_nettype none

module acip_rc_src
#(
   parameter int unsigned HALF_CYC = 5
)
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic run,
   output logic      rc_half_tick
);
   logic [7:0] cnt_ff;

   // ==========================================================
   // a stopped oscillator gives no ticks at all, so nothing clocked by it can move
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cnt_ff       <= 8'h00;
         rc_half_tick <= 1'b0;
      end
      else if (run)
      begin
         rc_half_tick <= (cnt_ff == 8'(HALF_CYC - 1));
         cnt_ff       <= (cnt_ff == 8'(HALF_CYC - 1)) ? 8'h00 : cnt_ff + 8'h01;
      end
      else
         rc_half_tick <= 1'b0;
   end
endmodule

`default_nettype wire

// ### sim/adc_input_ref_clock_select_tb.sv
// adc_input_ref_clock_select_tb: directed apb tests of channel, reference and conversion clock selection
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); end end

module adc_input_ref_clock_select_tb
   import acip_pkg::*;
;
   logic                 ref_clk = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 clk_en = 1'b1;
   logic [7:0]           paddr = 8'h00;
   logic                 psel = 1'b0;
   logic                 penable = 1'b0;
   logic                 pwrite = 1'b0;
   logic [31:0]          pwdata = 32'h0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 rc_run = 1'b0;
   logic                 rc_half_tick;
   logic [ROUTE_W-1:0]   sh_route;
   logic [PREF_SRCS-1:0] pos_ref_route;
   logic                 neg_ref_is_pin;
   logic                 conv_clk;
   logic                 conv_half_tick;
   logic                 bit_strobe;
   logic                 conv_busy;
   logic [31:0]          rd;
   logic                 err;
   int                   n_fail = 0;
   int                   num_checks = 0;

   always #4 ref_clk = ~ref_clk;

   acip_adc_cfg uut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rc_half_tick(rc_half_tick), .sh_route(sh_route), .pos_ref_route(pos_ref_route),
      .neg_ref_is_pin(neg_ref_is_pin), .conv_clk(conv_clk), .conv_half_tick(conv_half_tick),
      .bit_strobe(bit_strobe), .conv_busy(conv_busy));

   acip_rc_src #(.HALF_CYC(5)) u_rc (.ref_clk(ref_clk), .rst_n(rst_n), .run(rc_run), .rc_half_tick(rc_half_tick));

   // ==========================================================
   // bus and helpers
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         n_fail++;
         wrap_up;
      end
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic logic [ROUTE_W-1:0] exp_route(input logic [5:0] c);
      logic [ROUTE_W-1:0] r;
      r = '0;
      if (c <= 6'h22)
         r[c] = 1'b1;
      else if (c >= 6'h3c)
         r[RT_GND + int'(c - 6'h3c)] = 1'b1;
      return r;
   endfunction

   // cycles between two conversion half ticks, and the clock level seen at each
   task automatic half_gap(output int n, output logic c0, output logic c1);
      n = 0;
      while (conv_half_tick !== 1'b1 && n < 300)
      begin
         @(posedge ref_clk);
         n++;
      end
      c0 = conv_clk;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end
      while (conv_half_tick !== 1'b1 && n < 300);
      c1 = conv_clk;
   endtask

   // ==========================================================
   // scenarios
   task automatic t_reset;
      apb(1'b0, CHAN_OFS, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, REF_OFS, 32'h0);
      `CHK(rd, 32'h0)
      apb(1'b0, CLK_OFS, 32'h0);
      `CHK(rd, 32'h0)
      `CHK(sh_route, exp_route(6'h00))
      $display("test reset done");
   endtask

   task automatic t_channel;
      logic [5:0] codes [11] = '{6'h00, 6'h07, 6'h08, 6'h17, 6'h22, 6'h23, 6'h3b, 6'h3c, 6'h3d, 6'h3e, 6'h3f};
      foreach (codes[i])
      begin
         apb(1'b1, CHAN_OFS, {26'h0, codes[i]});
         repeat (2) @(posedge ref_clk);
         `CHK(sh_route, exp_route(codes[i]))
         `CHK(err, 1'b0)
      end
      $display("test channel done");
   endtask

   task automatic t_ref;
      logic [3:0] v;
      for (int i = 0; i < 16; i++)
      begin
         v = 4'(i);
         apb(1'b1, REF_OFS, {27'h0, v[3], 1'b0, v[2:0]});
         repeat (2) @(posedge ref_clk);
         `CHK(pos_ref_route, (v[2:0] < 3'h5) ? 5'(5'h01 << v[2:0]) : 5'h00)
         `CHK(neg_ref_is_pin, v[3])
      end
      $display("test reference done");
   endtask

   task automatic t_div;
      logic [5:0] divs [6] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h07, 6'h3f};
      int n;
      logic c0;
      logic c1;
      foreach (divs[i])
      begin
         apb(1'b1, CLK_OFS, {18'h0, divs[i], 8'h00});
         // a tick launched at the old rate is still in flight just after the write
         repeat (2) @(posedge ref_clk);
         half_gap(n, c0, c1);
         `CHK(2 * n, 2 * (int'(divs[i]) + 1))
         `CHK(c1, ~c0)
      end
      $display("test divider done");
   endtask

   task automatic t_rc;
      int n;
      logic c0;
      logic c1;
      apb(1'b1, CLK_OFS, 32'h1);
      apb(1'b1, CHAN_OFS, 32'h5);
      repeat (6) @(posedge ref_clk);
      `CHK(sh_route, exp_route(6'h3f))
      rc_run <= 1'b1;
      n = 0;
      while (sh_route !== exp_route(6'h05) && n < 40)
      begin
         @(posedge ref_clk);
         n++;
      end
      `CHK(sh_route, exp_route(6'h05))
      half_gap(n, c0, c1);
      `CHK(n, 5)
      apb(1'b1, CLK_OFS, 32'h0);
      repeat (12) @(posedge ref_clk);
      rc_run <= 1'b0;
      half_gap(n, c0, c1);
      `CHK(n, 1)
      $display("test rc clock done");
   endtask

   // clock enable low must freeze the divided conversion clock
   task automatic t_freeze;
      logic c;
      clk_en <= 1'b0;
      @(posedge ref_clk);
      c = conv_clk;
      repeat (20) @(posedge ref_clk);
      `CHK(conv_clk, c)
      clk_en <= 1'b1;
      repeat (2) @(posedge ref_clk);
      `CHK(conv_clk, ~c)
      $display("test freeze done");
   endtask

   task automatic t_conv;
      int k;
      int n;
      logic seen;
      apb(1'b1, CHAN_OFS, {26'h0, CH_GND});
      repeat (10) @(posedge ref_clk);
      apb(1'b1, CONV_OFS, 32'h1);
      k = 0;
      n = 0;
      seen = 1'b0;
      do
      begin
         @(posedge ref_clk);
         if (bit_strobe === 1'b1)
            k++;
         if (conv_busy === 1'b1)
            seen = 1'b1;
         n++;
      end
      while (!(seen && conv_busy === 1'b0) && n < 200);
      `CHK(k, 10)
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[DONE_BIT], 1'b1)
      apb(1'b1, STAT_OFS, 32'h2);
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[DONE_BIT], 1'b0)
      // early abort on the grounded channel discharges the hold capacitor without a result
      apb(1'b1, CONV_OFS, 32'h1);
      apb(1'b1, CONV_OFS, 32'h0);
      repeat (40) @(posedge ref_clk);
      apb(1'b0, STAT_OFS, 32'h0);
      `CHK(rd[1:0], 2'b00)
      `CHK(conv_busy, 1'b0)
      $display("test conversion done");
   endtask

   task automatic t_unmapped;
      apb(1'b1, 8'h14, 32'hffffffff);
      apb(1'b0, 8'h14, 32'h0);
      `CHK(err, 1'b1)
      `CHK(rd, 32'h0)
      $display("test unmapped done");
   endtask

   task automatic wrap_up;
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // sequence and watchdog
   initial
   begin
      #200000;
      n_fail++;
      wrap_up;
   end

   initial
   begin
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_reset;
      t_channel;
      t_ref;
      t_div;
      t_rc;
      t_freeze;
      t_conv;
      t_unmapped;
      wrap_up;
   end
endmodule

`default_nettype wire
